// >>> hdl/fpf_feed.sv
// Fixed-pitch feed with two or three axis linear interpolation
`timescale 1ns/10ps
module fpf_feed
  import fpf_pkg::*;
#(
  parameter int TW = FPF_TW,
  parameter int DIV = FPF_STEP_CYC
) (
  input wire logic clock, // System clock, 200 MHz
  input wire logic rst, // Synchronous reset, active high
  input wire logic start_input_bit, // Start bit from outside, asynchronous
  input wire fpf_cmd_t cmd, // Travel values and axis count, held during feed
  output fpf_drive_t drive, // Step and direction to the amplifiers
  output logic busy, // Feed in progress
  output logic done, // One-cycle completion pulse
  output logic signed [TW-1:0] pos_0, // Feed current position, axis 0
  output logic signed [TW-1:0] pos_1, // Feed current position, axis 1
  output logic signed [TW-1:0] pos_2 // Feed current position, axis 2
);
  typedef enum logic [1:0] {FPF_IDLE, FPF_RUN, FPF_DONE} fpf_state_t;

  logic tick;
  logic sync1_reg;
  logic sync2_reg;
  logic prev_reg;
  logic start_pulse;
  fpf_state_t state_reg;
  fpf_state_t state_next;
  logic [TW-1:0] mag_reg [FPF_AXES];
  logic [TW-1:0] mag_next [FPF_AXES];
  logic [TW-1:0] err_reg [FPF_AXES];
  logic [TW-1:0] err_next [FPF_AXES];
  logic [TW-1:0] cnt_reg [FPF_AXES];
  logic [TW-1:0] cnt_next [FPF_AXES];
  logic signed [TW-1:0] pos_reg [FPF_AXES];
  logic signed [TW-1:0] pos_next [FPF_AXES];
  logic [FPF_AXES-1:0] fwd_reg;
  logic [FPF_AXES-1:0] fwd_next;
  logic [FPF_AXES-1:0] step_reg;
  logic [FPF_AXES-1:0] step_next;
  logic [TW-1:0] major_reg;
  logic [TW-1:0] major_next;
  logic [TW-1:0] left_reg;
  logic [TW-1:0] left_next;
  logic done_reg;
  logic done_next;
  logic busy_reg;
  logic busy_next;
  logic signed [TW-1:0] trv [FPF_AXES];
  logic [TW-1:0] mag_in [FPF_AXES];

  fpf_tick #(.DIV(DIV)) u_tick (
    .clock(clock),
    .rst(rst),
    .tick(tick)
  );

  // Two-stage synchroniser, then edge detect on the second stage only
  always_ff @(posedge clock) begin
    if (rst) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      sync1_reg <= start_input_bit;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end
  assign start_pulse = sync2_reg & ~prev_reg;

  // Unused third axis reads as zero travel in the two-axis variant
  assign trv[0] = cmd.travel_0;
  assign trv[1] = cmd.travel_1;
  assign trv[2] = cmd.three_axis ? cmd.travel_2 : TW'(0);

  // Travel magnitudes; sign becomes direction
  for (genvar a = 0; a < FPF_AXES; a++) begin : g_mag
    assign mag_in[a] = trv[a][TW-1] ? TW'(-trv[a]) : TW'(trv[a]);
  end

  // Bresenham interpolation: the longest axis paces, others step on error overflow
  always_comb begin
    logic [TW-1:0] big;
    logic [TW:0] acc;
    big = '0;
    acc = '0;
    state_next = state_reg;
    major_next = major_reg;
    left_next = left_reg;
    fwd_next = fwd_reg;
    step_next = '0;
    done_next = 1'b0;
    for (int a = 0; a < FPF_AXES; a++) begin
      mag_next[a] = mag_reg[a];
      err_next[a] = err_reg[a];
      cnt_next[a] = cnt_reg[a];
      pos_next[a] = pos_reg[a];
    end
    unique case (state_reg)
      FPF_IDLE: begin
        if (start_pulse) begin
          for (int a = 0; a < FPF_AXES; a++) begin
            if (mag_in[a] > big) begin
              big = mag_in[a];
            end
          end
          for (int a = 0; a < FPF_AXES; a++) begin
            mag_next[a] = mag_in[a];
            err_next[a] = '0;
            cnt_next[a] = '0;
            pos_next[a] = '0;
            fwd_next[a] = ~trv[a][TW-1];
          end
          major_next = big;
          left_next = big;
          // Zero travel everywhere skips motion entirely
          state_next = (big == '0) ? FPF_DONE : FPF_RUN;
        end
      end
      FPF_RUN: begin
        if (tick) begin
          for (int a = 0; a < FPF_AXES; a++) begin
            acc = {1'b0, err_reg[a]} + {1'b0, mag_reg[a]};
            if (acc >= {1'b0, major_reg}) begin
              acc = acc - {1'b0, major_reg};
              step_next[a] = 1'b1;
              cnt_next[a] = cnt_reg[a] + TW'(1);
              pos_next[a] = fwd_reg[a] ? pos_reg[a] + TW'(1) : pos_reg[a] - TW'(1);
            end
            err_next[a] = acc[TW-1:0];
          end
          left_next = left_reg - TW'(1);
          // Major axis has no remainder, so all axes finish on the same tick
          if (left_reg == TW'(1)) begin
            state_next = FPF_DONE;
          end
        end
      end
      FPF_DONE: begin
        done_next = 1'b1;
        state_next = FPF_IDLE;
      end
      default: state_next = FPF_IDLE;
    endcase
    // Busy is registered so the pin never glitches on a state decode
    busy_next = (state_next == FPF_RUN);
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_reg <= FPF_IDLE;
      major_reg <= '0;
      left_reg <= '0;
      fwd_reg <= '0;
      step_reg <= '0;
      done_reg <= 1'b0;
      busy_reg <= 1'b0;
      for (int a = 0; a < FPF_AXES; a++) begin
        mag_reg[a] <= '0;
        err_reg[a] <= '0;
        cnt_reg[a] <= '0;
        pos_reg[a] <= TW'(FPF_POS_RST);
      end
    end else begin
      state_reg <= state_next;
      major_reg <= major_next;
      left_reg <= left_next;
      fwd_reg <= fwd_next;
      step_reg <= step_next;
      done_reg <= done_next;
      busy_reg <= busy_next;
      for (int a = 0; a < FPF_AXES; a++) begin
        mag_reg[a] <= mag_next[a];
        err_reg[a] <= err_next[a];
        cnt_reg[a] <= cnt_next[a];
        pos_reg[a] <= pos_next[a];
      end
    end
  end

  assign drive.step = step_reg;
  assign drive.fwd = fwd_reg;
  assign busy = busy_reg;
  assign done = done_reg;
  assign pos_0 = pos_reg[0];
  assign pos_1 = pos_reg[1];
  assign pos_2 = pos_reg[2];

  // Assertions
  a_zero_at_start: assert property (@(posedge clock) disable iff (rst)
    (state_reg == FPF_IDLE && start_pulse)
    |=> (pos_reg[0] == 0 && pos_reg[1] == 0 && pos_reg[2] == 0))
    else $error("position not cleared at start");
  a_zero_travel_done: assert property (@(posedge clock) disable iff (rst)
    (state_reg == FPF_IDLE && start_pulse && mag_in[0] == 0 && mag_in[1] == 0 && mag_in[2] == 0)
    |=> ##1 (done_reg && step_reg == 0))
    else $error("zero travel did not complete at once");
  a_done_full_travel: assert property (@(posedge clock) disable iff (rst)
    $rose(done_reg) |-> (cnt_reg[0] == mag_reg[0] && cnt_reg[1] == mag_reg[1]
    && cnt_reg[2] == mag_reg[2]))
    else $error("completion before full travel");
  a_dir_forward: assert property (@(posedge clock) disable iff (rst)
    (step_reg[0] && fwd_reg[0]) |-> (pos_reg[0] == $past(pos_reg[0]) + 1))
    else $error("forward step did not increase position");
  a_dir_reverse: assert property (@(posedge clock) disable iff (rst)
    (step_reg[0] && !fwd_reg[0]) |-> (pos_reg[0] == $past(pos_reg[0]) - 1))
    else $error("reverse step did not decrease position");
  a_interp_bound: assert property (@(posedge clock) disable iff (rst)
    (state_reg == FPF_RUN) |-> (cnt_reg[0] <= mag_reg[0] && cnt_reg[1] <= mag_reg[1]
    && cnt_reg[2] <= mag_reg[2]))
    else $error("axis overran its travel");
  a_two_axis_still: assert property (@(posedge clock) disable iff (rst)
    (state_reg == FPF_RUN && mag_reg[2] == 0) |-> ##1 !step_reg[2])
    else $error("idle axis stepped");
  a_start_edge: assert property (@(posedge clock) disable iff (rst)
    (state_reg == FPF_IDLE && !start_pulse) |=> state_reg == FPF_IDLE)
    else $error("feed started without edge");
endmodule // fpf_feed

// >>> hdl/fpf_pkg.sv
// Package: constants and types for the fixed-pitch feed interpolator
package fpf_pkg;
  localparam int FPF_AXES = 3;
  localparam int FPF_TW = 32;
  // Motion cycle period in ns and derived clock count at 200 MHz
  localparam int FPF_CLK_NS = 5;
  localparam int FPF_STEP_NS = 1000;
  localparam int FPF_STEP_CYC = (FPF_STEP_NS / FPF_CLK_NS) < 1 ? 1 : FPF_STEP_NS / FPF_CLK_NS;
  localparam logic [31:0] FPF_POS_RST = 32'h0000_0000;
  localparam logic [31:0] FPF_ZERO = 32'h0000_0000;
  // Feed command as presented by the program side
  typedef struct packed {
    logic three_axis;
    logic signed [FPF_TW-1:0] travel_2;
    logic signed [FPF_TW-1:0] travel_1;
    logic signed [FPF_TW-1:0] travel_0;
  } fpf_cmd_t;
  // Per-axis step pulses toward the servo amplifiers
  typedef struct packed {
    logic [FPF_AXES-1:0] step;
    logic [FPF_AXES-1:0] fwd;
  } fpf_drive_t;
endpackage

// >>> hdl/fpf_tick.sv
// Motion cycle enable divider
`timescale 1ns/10ps
module fpf_tick
  import fpf_pkg::*;
#(
  parameter int DIV = FPF_STEP_CYC
) (
  input wire logic clock, // System clock
  input wire logic rst, // Synchronous reset
  output logic tick // One-cycle motion cycle enable
);
  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  logic tick_reg;
  logic tick_next;

  // Free-running divider, wraps at DIV
  always_comb begin
    tick_next = 1'b0;
    cnt_next = cnt_reg + 16'h0001;
    if (cnt_reg == 16'(DIV - 1)) begin
      cnt_next = 16'h0000;
      tick_next = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      cnt_reg <= 16'h0000;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign tick = tick_reg;
endmodule // fpf_tick

// >>> verif/fpf_amp.sv
// Servo amplifier model: integrates step pulses into a position per axis
`timescale 1ns/10ps
module fpf_amp
  import fpf_pkg::*;
(
  input wire logic clock, // System clock
  input wire logic rst, // Synchronous reset
  input wire fpf_drive_t drive, // Step and direction from the feed
  output logic [FPF_AXES-1:0][31:0] cnt // Accumulated position per axis
);
  // One unit per pulse; direction is taken with the pulse, so a late fwd shows up
  always_ff @(posedge clock) begin
    for (int i = 0; i < FPF_AXES; i++) begin
      if (rst) begin
        cnt[i] <= 32'h0;
      end else if (drive.step[i]) begin
        cnt[i] <= drive.fwd[i] ? cnt[i] + 32'h1 : cnt[i] - 32'h1;
      end
    end
  end
endmodule // fpf_amp

// >>> verif/tb.sv
// Self-checking bench for the fixed-pitch feed interpolator
`timescale 1ns/10ps
module tb;
  import fpf_pkg::*;
  logic clock, rst, start_input_bit, busy, done, saw_busy;
  fpf_cmd_t cmd;
  fpf_drive_t drive;
  logic signed [31:0] pos_0, pos_1, pos_2;
  logic [2:0][31:0] cnt, base;
  int err_total, n_tests, nsteps;
  // Short motion tick keeps long feeds cheap
  fpf_feed #(.TW(32), .DIV(2)) dut (.clock(clock), .rst(rst),
    .start_input_bit(start_input_bit), .cmd(cmd), .drive(drive), .busy(busy),
    .done(done), .pos_0(pos_0), .pos_1(pos_1), .pos_2(pos_2));
  fpf_amp amp (.clock(clock), .rst(rst), .drive(drive), .cnt(cnt));
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // Compare and report
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task summarize;
    $display("checks=%0d errors=%0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  function automatic logic [31:0] mag(input logic [31:0] v);
    mag = v[31] ? -v : v;
  endfunction
  // One feed; poke retriggers start mid-run, which must be ignored
  task feed(input logic th, input logic [31:0] a, b, c, input bit poke);
    logic [2:0][31:0] e;
    int k;
    bit got;
    e = {th ? c : 32'h0, b, a};
    base = cnt;
    @(posedge clock);
    cmd <= {th, c, b, a};
    start_input_bit <= 1'b1;
    nsteps = 0;
    saw_busy = 1'b0;
    got = 0;
    for (k = 0; k < 3000 && !got; k++) begin
      @(posedge clock);
      nsteps += $countones(drive.step);
      saw_busy |= busy;
      got = (done === 1'b1);
      if (poke && k == 20) start_input_bit <= 1'b0;
      if (poke && k == 24) start_input_bit <= 1'b1;
    end
    // A hung feed counts once; the run still ends in the closing report
    if (!got) begin
      chk(32'h0, 32'h1);
      return;
    end
    chk(pos_0, e[0]);
    chk(pos_1, e[1]);
    chk(pos_2, e[2]);
    for (int i = 0; i < 3; i++) begin
      chk(cnt[i] - base[i], e[i]);
      if (e[i] != 32'h0) chk({31'h0, drive.fwd[i]}, {31'h0, ~e[i][31]});
    end
    chk(32'(nsteps), mag(e[0]) + mag(e[1]) + mag(e[2]));
    chk({31'h0, saw_busy}, {31'h0, e != '0});
    @(posedge clock);
    start_input_bit <= 1'b0;
    // A start edge seen while moving must not launch another feed
    repeat (8) begin
      @(posedge clock);
      chk({31'h0, busy}, 32'h0);
    end
  endtask
  function automatic logic [31:0] rnd();
    rnd = 32'($urandom_range(40)) - 32'd20;
  endfunction
  initial begin
    err_total = 0;
    n_tests = 0;
    rst = 1'b1;
    start_input_bit = 1'b0;
    cmd = '0;
    void'($urandom(32'hbf8f8fbe));
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    // Corner cases: all-zero in both modes, long runs with a retrigger, one zero axis
    feed(1'b0, 32'h0, 32'h0, 32'h0, 0);
    feed(1'b1, 32'h0, 32'h0, 32'h0, 0);
    feed(1'b0, 32'd50, -32'd30, 32'd7, 1);
    feed(1'b1, 32'd50, 32'd40, -32'd30, 1);
    feed(1'b1, -32'd17, 32'h0, 32'd5, 0);
    feed(1'b1, 32'h1, -32'h1, 32'h1, 0);
    // Random travels, kept nonzero as the commander should
    repeat (8) feed(1'($urandom), rnd() | 32'h1, rnd() | 32'h1, rnd() | 32'h1, 0);
    // Reset in mid-feed: outputs return to rest, then a fresh feed runs normally
    @(posedge clock);
    cmd <= {1'b1, -32'd10, 32'd25, 32'd40};
    start_input_bit <= 1'b1;
    repeat (30) @(posedge clock);
    rst <= 1'b1;
    start_input_bit <= 1'b0;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    chk({31'h0, busy}, 32'h0);
    chk({29'h0, drive.step}, 32'h0);
    chk(pos_0 | pos_1 | pos_2, 32'h0);
    feed(1'b1, 32'd12, -32'd12, 32'd3, 0);
    summarize;
  end
endmodule // tb
